// ### cpu_ops_pkg.sv
// Overview of operation
// - Call advances program counter, pushes low then high byte, then jumps.
// - Call takes 5/6/7/6/5 cycles for direct/extended/ix2/ix1/ix forms.
// - Load accumulator from memory; negative and zero follow, others kept.
// - Load index from memory; negative and zero follow, others kept.
// - Loads take 2/3/4/5/4/3 cycles for imm/dir/ext/ix2/ix1/ix.
// - Shift left: zero into bit 0, old bit 7 to carry, N and Z updated.
// - Arithmetic and logical left shift share one encoding and one operation.
// - Shift right: zero into bit 7, old bit 0 to carry, N cleared, Z updated.
// - Multiply index by accumulator, high byte to index, clear H and C.
// - Negate operand as zero minus value; N, Z and C updated.
// - OR memory into accumulator; N and Z updated, carry kept.
// - OR takes 2/3/4/5/4/3 cycles for imm/dir/ext/ix2/ix1/ix.
// - Rotate left through carry; N and Z updated.
// - Stack stays within 00C0 to 00FF and wraps back to 00FF.
// - Program counter is 13 bits and increments after each fetch.
package cpu_ops_pkg;

  // Core register reset values
  localparam logic [12:0] PC_RST   = 13'h0000;
  localparam logic [5:0]  SP_RST   = 6'h3f;
  localparam logic [6:0]  SP_FIXED = 7'h03;
  localparam logic [7:0]  DATA_RST = 8'h00;
  localparam logic [4:0]  CCR_RST  = 5'h08;
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_HALT_BIT = 1;

  // Register port offsets
  localparam logic [2:0] REG_ACC  = 3'h0;
  localparam logic [2:0] REG_IDX  = 3'h1;
  localparam logic [2:0] REG_CCR  = 3'h2;
  localparam logic [2:0] REG_SP   = 3'h3;
  localparam logic [2:0] REG_PCH  = 3'h4;
  localparam logic [2:0] REG_PCL  = 3'h5;
  localparam logic [2:0] REG_CTRL = 3'h6;

  // Opcode fields
  localparam logic [3:0] HI_IMM   = 4'ha;
  localparam logic [3:0] HI_DIR   = 4'hb;
  localparam logic [3:0] HI_EXT   = 4'hc;
  localparam logic [3:0] HI_IX2   = 4'hd;
  localparam logic [3:0] HI_IX1   = 4'he;
  localparam logic [3:0] HI_IX    = 4'hf;
  localparam logic [3:0] RMW_DIR  = 4'h3;
  localparam logic [3:0] RMW_INHA = 4'h4;
  localparam logic [3:0] RMW_INHX = 4'h5;
  localparam logic [3:0] RMW_IX1  = 4'h6;
  localparam logic [3:0] RMW_IX   = 4'h7;
  localparam logic [3:0] LO_LOADA = 4'h6;
  localparam logic [3:0] LO_LOADX = 4'he;
  localparam logic [3:0] LO_OR    = 4'ha;
  localparam logic [3:0] LO_CALL  = 4'hd;
  localparam logic [3:0] LO_SHL   = 4'h8;
  localparam logic [3:0] LO_SHR   = 4'h4;
  localparam logic [3:0] LO_NEG   = 4'h0;
  localparam logic [3:0] LO_ROTL  = 4'h9;
  localparam logic [7:0] OPC_MUL  = 8'h42;

  // Cycle counts per instruction form
  localparam logic [3:0] CYC_LD_IMM = 4'h2;
  localparam logic [3:0] CYC_LD_DIR = 4'h3;
  localparam logic [3:0] CYC_LD_EXT = 4'h4;
  localparam logic [3:0] CYC_LD_IX2 = 4'h5;
  localparam logic [3:0] CYC_LD_IX1 = 4'h4;
  localparam logic [3:0] CYC_LD_IX  = 4'h3;
  localparam logic [3:0] CYC_JS_DIR = 4'h5;
  localparam logic [3:0] CYC_JS_EXT = 4'h6;
  localparam logic [3:0] CYC_JS_IX2 = 4'h7;
  localparam logic [3:0] CYC_JS_IX1 = 4'h6;
  localparam logic [3:0] CYC_JS_IX  = 4'h5;
  localparam logic [3:0] CYC_RM_DIR = 4'h5;
  localparam logic [3:0] CYC_RM_INH = 4'h3;
  localparam logic [3:0] CYC_RM_IX1 = 4'h6;
  localparam logic [3:0] CYC_RM_IX  = 4'h5;
  localparam logic [3:0] CYC_MUL    = 4'h1;
  localparam logic [3:0] CYC_NOP    = 4'h2;

  typedef enum logic [2:0] {AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX2, AM_IX1, AM_IX} amode_t;
  typedef enum logic [2:0] {OP_NOP, OP_LOAD, OP_OR, OP_SHL, OP_SHR, OP_NEG, OP_ROTL,
                            OP_MUL} alu_op_t;
  typedef enum logic [1:0] {DST_NONE, DST_A, DST_X, DST_M} dst_t;

  // Gray codes along fetch, operand, data, write
  typedef enum logic [3:0] {
    S_FETCH = 4'h0, S_OPR1 = 4'h1, S_OPR2 = 4'h3, S_DATA = 4'h2, S_WRITE = 4'h6,
    S_PUSHL = 4'h7, S_PUSHH = 4'h5, S_PAD = 4'h4, S_HALT = 4'hc
  } state_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } ccr_t;

  typedef struct packed {
    logic [12:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    amode_t     mode;
    alu_op_t    op;
    dst_t       dst;
    logic       call;
    logic [3:0] cyc;
  } dec_t;

  localparam mem_req_t MEM_IDLE = '{addr: 13'h0000, rd: 1'b0, wr: 1'b0, wdata: 8'h00};

endpackage

// ### cpu_alu.sv
`timescale 1ns/10ps
module cpu_alu
  import cpu_ops_pkg::*;
(
  input  alu_op_t          op_i,
  input  wire logic [7:0]  opnd_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  idx_i,
  input  ccr_t             ccr_i,
  output logic [7:0]       res_o,
  output logic [15:0]      prod_o,
  output ccr_t             ccr_o
);

  assign prod_o = {8'h00, idx_i} * {8'h00, acc_i};

  // Result and flags; untouched flags pass through
  always_comb begin
    res_o = opnd_i;
    ccr_o = ccr_i;
    case (op_i)
      OP_LOAD: res_o = opnd_i;
      OP_OR:   res_o = acc_i | opnd_i;
      OP_SHL: begin
        res_o   = {opnd_i[6:0], 1'b0};
        ccr_o.c = opnd_i[7];
      end
      OP_SHR: begin
        res_o   = {1'b0, opnd_i[7:1]};
        ccr_o.c = opnd_i[0];
      end
      OP_NEG: begin
        res_o   = 8'h00 - opnd_i;
        ccr_o.c = |opnd_i;
      end
      OP_ROTL: begin
        res_o   = {opnd_i[6:0], ccr_i.c};
        ccr_o.c = opnd_i[7];
      end
      default: res_o = opnd_i;
    endcase
    if (op_i == OP_MUL) begin
      ccr_o.h = 1'b0;
      ccr_o.c = 1'b0;
    end else if (op_i != OP_NOP) begin
      ccr_o.n = (op_i == OP_SHR) ? 1'b0 : res_o[7];
      ccr_o.z = (res_o == 8'h00);
    end
  end

endmodule

// ### cpu_op_core.sv
`timescale 1ns/10ps
module cpu_op_core
  import cpu_ops_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  output mem_req_t         mem_req_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o
);

  state_t      state_reg, state_next;
  logic [12:0] pc_reg, pc_next;
  logic [5:0]  sp_reg, sp_next;
  logic [7:0]  acc_reg, acc_next;
  logic [7:0]  idx_reg, idx_next;
  ccr_t        ccr_reg, ccr_next;
  logic [7:0]  opc_reg, opc_next;
  logic [7:0]  hi_reg, hi_next;
  logic [12:0] ea_reg, ea_next;
  logic [3:0]  cnt_reg, cnt_next;
  mem_req_t    req_reg, req_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        finish;
  logic        do_exec;

  // Opcode decode
  function automatic dec_t decode(input logic [7:0] o);
    dec_t       d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [3:0] ld_c;
    logic [3:0] js_c;
    logic [3:0] rm_c;
    hi   = o[7:4];
    lo   = o[3:0];
    d    = '{mode: AM_INH, op: OP_NOP, dst: DST_NONE, call: 1'b0, cyc: CYC_NOP};
    ld_c = CYC_NOP;
    js_c = CYC_NOP;
    rm_c = CYC_NOP;
    case (hi)
      HI_IMM: begin d.mode = AM_IMM; ld_c = CYC_LD_IMM; end
      HI_DIR: begin d.mode = AM_DIR; ld_c = CYC_LD_DIR; js_c = CYC_JS_DIR; end
      HI_EXT: begin d.mode = AM_EXT; ld_c = CYC_LD_EXT; js_c = CYC_JS_EXT; end
      HI_IX2: begin d.mode = AM_IX2; ld_c = CYC_LD_IX2; js_c = CYC_JS_IX2; end
      HI_IX1: begin d.mode = AM_IX1; ld_c = CYC_LD_IX1; js_c = CYC_JS_IX1; end
      HI_IX:  begin d.mode = AM_IX;  ld_c = CYC_LD_IX;  js_c = CYC_JS_IX;  end
      RMW_DIR: begin d.mode = AM_DIR; rm_c = CYC_RM_DIR; end
      RMW_INHA: rm_c = CYC_RM_INH;
      RMW_INHX: rm_c = CYC_RM_INH;
      RMW_IX1: begin d.mode = AM_IX1; rm_c = CYC_RM_IX1; end
      RMW_IX:  begin d.mode = AM_IX;  rm_c = CYC_RM_IX;  end
      default: d.mode = AM_INH;
    endcase
    if (hi >= HI_IMM) begin
      d.cyc = ld_c;
      if (lo == LO_LOADA) begin
        d.op  = OP_LOAD;
        d.dst = DST_A;
      end else if (lo == LO_LOADX) begin
        d.op  = OP_LOAD;
        d.dst = DST_X;
      end else if (lo == LO_OR) begin
        d.op  = OP_OR;
        d.dst = DST_A;
      end else if (lo == LO_CALL && hi != HI_IMM) begin
        d.call = 1'b1;
        d.cyc  = js_c;
      end else begin
        d.mode = AM_INH;
        d.cyc  = CYC_NOP;
      end
    end else if (o == OPC_MUL) begin
      d.op  = OP_MUL;
      d.cyc = CYC_MUL;
    end else if (hi >= RMW_DIR && hi <= RMW_IX) begin
      d.cyc = rm_c;
      d.dst = (hi == RMW_INHA) ? DST_A : (hi == RMW_INHX) ? DST_X : DST_M;
      if (lo == LO_SHL) begin
        d.op = OP_SHL;
      end else if (lo == LO_SHR) begin
        d.op = OP_SHR;
      end else if (lo == LO_NEG) begin
        d.op = OP_NEG;
      end else if (lo == LO_ROTL) begin
        d.op = OP_ROTL;
      end else begin
        d.mode = AM_INH;
        d.dst  = DST_NONE;
        d.cyc  = CYC_NOP;
      end
    end
    return d;
  endfunction

  // Decode and operand selection
  wire logic [7:0]  cur_opc = (state_reg == S_FETCH) ? mem_rdata_i : opc_reg;
  wire dec_t        dec     = decode(cur_opc);
  wire logic [3:0]  cnt_now = (state_reg == S_FETCH) ? 4'h0 : cnt_reg;
  wire logic        run     = ctrl_reg[CTRL_RUN_BIT];
  wire logic [7:0]  inh_opnd = (dec.dst == DST_X) ? idx_reg : acc_reg;
  wire logic [7:0]  alu_opnd = (dec.mode == AM_INH) ? inh_opnd : mem_rdata_i;
  wire logic [12:0] idx_ext = {5'h00, idx_reg};
  wire logic [12:0] byte_ext = {5'h00, mem_rdata_i};
  wire logic [12:0] pc_inc  = pc_reg + 13'h0001;
  wire logic [5:0]  sp_dec  = sp_reg - 6'h01;
  wire logic        halted  = (state_reg == S_HALT);
  wire logic [7:0]  alu_res;
  wire logic [15:0] alu_prod;
  wire ccr_t        alu_ccr;

  cpu_alu u_alu (
    .op_i   (dec.op),
    .opnd_i (alu_opnd),
    .acc_i  (acc_reg),
    .idx_i  (idx_reg),
    .ccr_i  (ccr_reg),
    .res_o  (alu_res),
    .prod_o (alu_prod),
    .ccr_o  (alu_ccr)
  );

  // Sequencer: one bus access per cycle, padded to the cycle count
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    acc_next   = acc_reg;
    idx_next   = idx_reg;
    ccr_next   = ccr_reg;
    opc_next   = opc_reg;
    hi_next    = hi_reg;
    ea_next    = ea_reg;
    cnt_next   = cnt_now + 4'h1;
    req_next   = MEM_IDLE;
    finish     = 1'b0;
    do_exec    = 1'b0;
    case (state_reg)
      S_FETCH: begin
        opc_next = mem_rdata_i;
        pc_next  = pc_inc;
        if (dec.mode == AM_INH) begin
          do_exec = 1'b1;
          finish  = 1'b1;
        end else if (dec.mode == AM_IX) begin
          ea_next    = idx_ext;
          state_next = dec.call ? S_PUSHL : S_DATA;
        end else begin
          state_next = S_OPR1;
        end
      end
      S_OPR1: begin
        pc_next = pc_inc;
        case (dec.mode)
          AM_IMM: begin
            do_exec = 1'b1;
            finish  = 1'b1;
          end
          AM_DIR: begin
            ea_next    = byte_ext;
            state_next = dec.call ? S_PUSHL : S_DATA;
          end
          AM_IX1: begin
            ea_next    = byte_ext + idx_ext;
            state_next = dec.call ? S_PUSHL : S_DATA;
          end
          default: begin
            hi_next    = mem_rdata_i;
            state_next = S_OPR2;
          end
        endcase
      end
      S_OPR2: begin
        pc_next    = pc_inc;
        ea_next    = {hi_reg[4:0], mem_rdata_i} + ((dec.mode == AM_IX2) ? idx_ext : 13'h0000);
        state_next = dec.call ? S_PUSHL : S_DATA;
      end
      S_DATA: begin
        do_exec = 1'b1;
        if (dec.dst == DST_M) begin
          state_next = S_WRITE;
        end else begin
          finish = 1'b1;
        end
      end
      S_PUSHL: begin
        sp_next    = sp_dec;
        state_next = S_PUSHH;
      end
      S_PUSHH: begin
        sp_next = sp_dec;
        pc_next = ea_reg;
        finish  = 1'b1;
      end
      S_WRITE: finish = 1'b1;
      S_PAD:   finish = 1'b1;
      S_HALT: begin
        if (run) begin
          state_next = S_FETCH;
        end
      end
      default: state_next = S_HALT;
    endcase
    // Apply the ALU result to its destination
    if (do_exec) begin
      ccr_next = alu_ccr;
      if (dec.op == OP_MUL) begin
        idx_next = alu_prod[15:8];
        acc_next = alu_prod[7:0];
      end else if (dec.dst == DST_A) begin
        acc_next = alu_res;
      end else if (dec.dst == DST_X) begin
        idx_next = alu_res;
      end
    end
    // Stretch each instruction to its documented length
    if (finish) begin
      if (cnt_now + 4'h1 >= dec.cyc) begin
        state_next = run ? S_FETCH : S_HALT;
      end else begin
        state_next = S_PAD;
      end
    end
    // Bus access for the coming cycle
    case (state_next)
      S_FETCH, S_OPR1, S_OPR2: begin
        req_next.addr = pc_next;
        req_next.rd   = 1'b1;
      end
      S_DATA: begin
        req_next.addr = ea_next;
        req_next.rd   = 1'b1;
      end
      S_WRITE: begin
        req_next.addr  = ea_reg;
        req_next.wr    = 1'b1;
        req_next.wdata = alu_res;
      end
      S_PUSHL: begin
        req_next.addr  = {SP_FIXED, sp_next};
        req_next.wr    = 1'b1;
        req_next.wdata = pc_next[7:0];
      end
      S_PUSHH: begin
        req_next.addr  = {SP_FIXED, sp_next};
        req_next.wr    = 1'b1;
        req_next.wdata = {3'h0, pc_reg[12:8]};
      end
      default: req_next = MEM_IDLE;
    endcase
    // Software loads core registers only while halted
    if (halted && reg_wr_i) begin
      if (reg_addr_i == REG_ACC) begin
        acc_next = reg_wdata_i;
      end else if (reg_addr_i == REG_IDX) begin
        idx_next = reg_wdata_i;
      end else if (reg_addr_i == REG_CCR) begin
        ccr_next = reg_wdata_i[4:0];
      end else if (reg_addr_i == REG_SP) begin
        sp_next = reg_wdata_i[5:0];
      end else if (reg_addr_i == REG_PCH) begin
        pc_next = {reg_wdata_i[4:0], pc_reg[7:0]};
      end else if (reg_addr_i == REG_PCL) begin
        pc_next = {pc_reg[12:8], reg_wdata_i};
      end
    end
  end

  // Register port: control write and read mux
  assign ctrl_next = (reg_wr_i && reg_addr_i == REG_CTRL) ? reg_wdata_i : ctrl_reg;

  wire logic [7:0] ctrl_rd = {6'h00, halted, run};
  wire logic [7:0] rd_mux =
    (reg_addr_i == REG_ACC)  ? acc_reg :
    (reg_addr_i == REG_IDX)  ? idx_reg :
    (reg_addr_i == REG_CCR)  ? {3'h0, ccr_reg} :
    (reg_addr_i == REG_SP)   ? {2'h0, sp_reg} :
    (reg_addr_i == REG_PCH)  ? {3'h0, pc_reg[12:8]} :
    (reg_addr_i == REG_PCL)  ? pc_reg[7:0] :
    (reg_addr_i == REG_CTRL) ? ctrl_rd : 8'h00;

  assign rdata_next = reg_rd_i ? rd_mux : 8'h00;

  // Core state
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= S_HALT;
      pc_reg    <= PC_RST;
      sp_reg    <= SP_RST;
      acc_reg   <= DATA_RST;
      idx_reg   <= DATA_RST;
      ccr_reg   <= CCR_RST;
      opc_reg   <= DATA_RST;
      hi_reg    <= DATA_RST;
      ea_reg    <= PC_RST;
      cnt_reg   <= 4'h0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      sp_reg    <= sp_next;
      acc_reg   <= acc_next;
      idx_reg   <= idx_next;
      ccr_reg   <= ccr_next;
      opc_reg   <= opc_next;
      hi_reg    <= hi_next;
      ea_reg    <= ea_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Bus and register port outputs
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_reg   <= MEM_IDLE;
      ctrl_reg  <= CTRL_RST;
      rdata_reg <= DATA_RST;
    end else if (clk_en_i) begin
      req_reg   <= req_next;
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign mem_req_o   = req_reg;
  assign reg_rdata_o = rdata_reg;

endmodule

// ### cpu_mem_model.sv
`timescale 1ns/10ps
module cpu_mem_model
  import cpu_ops_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  mem_req_t        mem_req_i,
  output logic [7:0]      mem_rdata_o
);
  logic [7:0] mem [0:8191];
  logic [7:0] last_reg = 8'h00;

  // Same-cycle read; an unread bus shows a byte that flips every cycle
  assign mem_rdata_o = mem_req_i.rd ? mem[mem_req_i.addr] : ~last_reg;

  // Writes land at the edge that ends the cycle
  always @(posedge ref_clk_i) begin
    if (mem_req_i.wr) begin
      mem[mem_req_i.addr] <= mem_req_i.wdata;
    end
    last_reg <= mem_rdata_o;
  end
endmodule

// ### cpu_op_core_asserts.sv
`timescale 1ns/10ps
module cpu_op_core_asserts
  import cpu_ops_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  mem_req_t         mem_req_o,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  logic [7:0]       reg_rdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Two writes in a row only come from a call pushing its return address
  sequence s_push;
    mem_req_o.wr ##1 mem_req_o.wr;
  endsequence
  // Single write right after a read is a read-modify-write
  sequence s_rmw;
    $past(mem_req_o.rd) && mem_req_o.wr ##1 !mem_req_o.wr;
  endsequence

  property p_push_page;
    s_push |-> mem_req_o.addr[12:6] == 7'h03 && $past(mem_req_o.addr[12:6]) == 7'h03;
  endproperty
  a_push_page: assert property (p_push_page) else $error("push outside stack page");
  property p_push_dec;
    s_push |-> mem_req_o.addr[5:0] == 6'($past(mem_req_o.addr[5:0]) - 6'd1);
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push address not one below");
  property p_push_hi;
    s_push |-> mem_req_o.wdata[7:5] == 3'b000;
  endproperty
  a_push_hi: assert property (p_push_hi) else $error("high return byte too wide");
  property p_call_pad;
    s_push |=> !mem_req_o.rd && !mem_req_o.wr;
  endproperty
  a_call_pad: assert property (p_call_pad) else $error("no idle cycle after pushes");
  property p_rmw_addr;
    s_rmw |-> $past(mem_req_o.addr) == $past(mem_req_o.addr, 2);
  endproperty
  a_rmw_addr: assert property (p_rmw_addr) else $error("write back to other address");
  property p_rmw_pad;
    s_rmw |-> !mem_req_o.rd;
  endproperty
  a_rmw_pad: assert property (p_rmw_pad) else $error("no idle cycle after write back");
  property p_rw_excl;
    !(mem_req_o.rd && mem_req_o.wr);
  endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("read and write together");
  property p_rdata_zero;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer");
  property p_rd_gap;
    reg_rd_i && clk_en_i && reg_addr_i == 3'h7 |=> reg_rdata_o == 8'h00;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped offset not zero");
endmodule

bind cpu_op_core cpu_op_core_asserts i_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .clk_en_i(clk_en_i), .mem_req_o(mem_req_o), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

// ### cpu_op_core_tb.sv
`timescale 1ns/10ps
module cpu_op_core_tb
  import cpu_ops_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic [7:0]  reg_rdata_o;
  logic [7:0]  mem_rdata_i;
  mem_req_t    mem_req_o;
  logic [12:0] start_a = 13'h1000;
  logic [12:0] next_a;
  logic [7:0]  g;
  logic        wrap_stk;
  int          err_total = 0;
  int          comparisons = 0;
  int          seed = 32'h3666;
  int          cycle_cnt = 0;
  int          t0;
  int          t1;
  // Opcode and expected cycle count
  logic [11:0] tv [39] = '{12'ha62, 12'hbe3, 12'hce4, 12'hd65, 12'he64, 12'hf63, 12'haa2,
    12'hba3, 12'hca4, 12'hda5, 12'hea4, 12'hfa3, 12'hae2, 12'h483, 12'h583, 12'h385, 12'h686,
    12'h785, 12'h443, 12'h543, 12'h345, 12'h646, 12'h745, 12'h403, 12'h503, 12'h305, 12'h606,
    12'h705, 12'h493, 12'h593, 12'h395, 12'h696, 12'h795, 12'h421, 12'hbd5, 12'hcd6, 12'hdd7,
    12'hed6, 12'hfd5};

  cpu_op_core i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  cpu_mem_model i_mem (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i));

  always #50 ref_clk_i = ~ref_clk_i;

  // Cycle ceiling
  always @(posedge ref_clk_i) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      err_total++;
      print_verdict;
    end
  end

  // Opcode fetch times at start and at the following instruction
  always @(negedge ref_clk_i) begin
    if (mem_req_o.rd === 1'b1 && mem_req_o.addr === start_a && t0 < 0) t0 = cycle_cnt;
    else if (mem_req_o.rd === 1'b1 && mem_req_o.addr === next_a && t0 >= 0 && t1 < 0)
      t1 = cycle_cnt;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("wrong value at %0t: %0d cycles, expected %0d", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
  endtask

  // Expected {a, x, m, flags} after one instruction
  function automatic logic [31:0] model(input logic [7:0] op, a, x, m, input logic [4:0] f);
    logic [7:0]  v;
    logic [7:0]  r;
    logic [15:0] p;
    if (op[3:0] == 4'hd) return {a, x, m, 3'b000, f};
    if (op == OPC_MUL) begin
      p = x * a;
      return {p[7:0], p[15:8], m, 3'b000, 1'b0, f[3:1], 1'b0};
    end
    v = (op[7:4] == 4'h4) ? a : (op[7:4] == 4'h5) ? x : m;
    case (op[3:0])
      4'h0: begin r = 8'h00 - v; f[0] = (r != 8'h00); end
      4'h4: begin r = {1'b0, v[7:1]}; f[0] = v[0]; end
      4'h8: begin r = {v[6:0], 1'b0}; f[0] = v[7]; end
      4'h9: begin r = {v[6:0], f[0]}; f[0] = v[7]; end
      4'ha: r = a | m;
      default: r = m;
    endcase
    f[2] = r[7];
    f[1] = (r == 8'h00);
    if (op[7:4] == 4'h4 || op[3:0] == 4'h6 || op[3:0] == 4'ha) a = r;
    else if (op[7:4] == 4'h5 || op[3:0] == 4'he) x = r;
    else m = r;
    return {a, x, m, 3'b000, f};
  endfunction

  // Set up registers, run one instruction, stop, read back
  task automatic run_op(input logic [7:0] op, input int ncyc);
    logic [7:0]  a, x, m, b1, b2, gv;
    logic [4:0]  f;
    logic [5:0]  stk;
    logic [12:0] ea, ret;
    logic [31:0] e;
    logic        call;
    int          len;
    call = (op[3:0] == 4'hd);
    a = $random(seed);
    x = $random(seed);
    b1 = $random(seed);
    b2 = $random(seed);
    f = $random(seed);
    stk = wrap_stk ? 6'h00 : 6'($random(seed));
    if (call) x[7] = 1'b0;
    if (op[7:4] == 4'hc) b1 = 8'h03;
    if (op[7:4] == 4'hd) b1 = 8'h02;
    if (op == 8'hbd) b1 = 8'h40;
    if (op == 8'hed) b1 = 8'h20;
    len = (op[7:4] inside {4'h4, 4'h5, 4'h7, 4'hf}) ? 1 : (op[7:4] inside {4'hc, 4'hd}) ? 3 : 2;
    case (op[7:4])
      4'h3, 4'hb: ea = {5'h00, b1};
      4'hc: ea = {b1[4:0], b2};
      4'hd: ea = {b1[4:0], b2} + 13'(x);
      4'h6, 4'he: ea = 13'(b1) + 13'(x);
      default: ea = {5'h00, x};
    endcase
    m = call ? 8'h9d : (op[7:4] == 4'ha) ? b1 : 8'($random(seed));
    ret = start_a + 13'(len);
    next_a = call ? ea : ret;
    for (int i = 0; i < 16; i++) i_mem.mem[start_a + 13'(i)] = 8'h9d;
    i_mem.mem[start_a] = op;
    if (len > 1) i_mem.mem[start_a + 13'h1] = b1;
    if (len > 2) i_mem.mem[start_a + 13'h2] = b2;
    for (int i = 0; i < (call ? 16 : 1); i++) i_mem.mem[ea + 13'(i)] = m;
    reg_wr(REG_ACC, a);
    reg_wr(REG_IDX, x);
    reg_wr(REG_CCR, {3'b000, f});
    reg_wr(REG_SP, {2'b00, stk});
    reg_wr(REG_PCH, 8'h10);
    reg_wr(REG_PCL, 8'h00);
    t0 = -1;
    t1 = -1;
    reg_wr(REG_CTRL, 8'h01);
    for (int k = 0; k < 40 && t1 < 0; k++) @(posedge ref_clk_i);
    reg_wr(REG_CTRL, 8'h00);
    gv = 8'h00;
    for (int k = 0; k < 20 && gv[1] !== 1'b1; k++) reg_rd(REG_CTRL, gv);
    chk_cnt(t1 - t0, ncyc);
    e = model(op, a, x, m, f);
    reg_rd(REG_ACC, gv);
    chk(gv, e[31:24]);
    reg_rd(REG_IDX, gv);
    chk(gv, e[23:16]);
    reg_rd(REG_CCR, gv);
    chk(gv, e[7:0]);
    chk(i_mem.mem[ea], e[15:8]);
    reg_rd(REG_SP, gv);
    chk(gv, {2'b00, 6'(stk - (call ? 6'd2 : 6'd0))});
    if (call) begin
      chk(i_mem.mem[{7'h03, stk}], ret[7:0]);
      chk(i_mem.mem[{7'h03, 6'(stk - 6'd1)}], {3'b000, ret[12:8]});
    end
  endtask

  // Reset, reset values, then the 39 opcodes of the table in several rounds
  initial begin
    for (int i = 0; i < 8192; i++) i_mem.mem[i] = 8'h9d;
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    reg_rd(REG_SP, g);
    chk(g, {2'b00, SP_RST});
    reg_rd(3'h7, g);
    chk(g, 8'h00);
    // Frozen clock enable: a register write must not land
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    reg_wr(REG_ACC, 8'h5a);
    clk_en_i <= 1'b1;
    reg_rd(REG_ACC, g);
    chk(g, DATA_RST);
    for (int n = 0; n < 3; n++) begin
      wrap_stk = (n == 0);
      foreach (tv[j]) run_op(tv[j][11:4], int'(tv[j][3:0]));
    end
    print_verdict;
  end
endmodule
